// ### logic/wdio_pkg.sv
// package for the board watchdog and i/o control block
// assumes a 200 MHz clock and a byte-wide i/o port bus from the host cpu
package wdio_pkg;

  // ==========================================================================
  // port addresses
  localparam logic [9:0] ADDR_WD_CMD     = 10'h270;
  localparam logic [9:0] ADDR_SERIAL_LO  = 10'h271;
  localparam logic [9:0] ADDR_SERIAL_HI  = 10'h272;
  localparam logic [9:0] ADDR_EEPROM     = 10'h285;
  localparam logic [9:0] ADDR_VERSION    = 10'h28e;
  localparam logic [9:0] ADDR_IDENTITY   = 10'h28f;
  localparam logic [9:0] ADDR_WD_TIMEOUT = 10'h290;
  localparam logic [9:0] ADDR_LINE_MODE  = 10'h291;
  localparam logic [9:0] ADDR_DL_CTRL    = 10'h292;
  localparam logic [9:0] ADDR_WP_UNLOCK  = 10'h293;

  // decoded windows: base and last address
  localparam logic [9:0] WIN_WD_BASE     = 10'h270;
  localparam logic [9:0] WIN_WD_LAST     = 10'h277;
  localparam logic [9:0] WIN_ID_BASE     = 10'h280;
  localparam logic [9:0] WIN_ID_LAST     = 10'h28f;
  localparam logic [9:0] WIN_CTL_BASE    = 10'h290;
  localparam logic [9:0] WIN_CTL_LAST    = 10'h297;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_WD_ON       = 8'h40;
  localparam logic [7:0] CMD_WD_OFF      = 8'h50;
  localparam logic [7:0] CMD_TRIG_FIRST  = 8'h60;
  localparam logic [7:0] CMD_TRIG_SECOND = 8'h70;

  localparam logic [7:0] WP_STEP_A       = 8'h03;
  localparam logic [7:0] WP_STEP_B       = 8'h06;
  localparam logic [7:0] WP_UNLOCK_CODE  = 8'h01;
  localparam logic [7:0] WP_LOCK_CODE    = 8'h00;

  // ==========================================================================
  // reset values and field positions
  localparam logic [7:0] TIMEOUT_RESET   = 8'h00;
  localparam logic [7:0] LINE_MODE_RESET = 8'h00;
  localparam logic [7:0] DL_CTRL_RESET   = 8'h00;
  localparam logic [7:0] LINE_MODE_MASK  = 8'h07;
  localparam int         LM_DIFF_BIT     = 0;
  localparam int         LM_B1_BIT       = 1;
  localparam int         LM_B2_BIT       = 2;

  // ==========================================================================
  // timing
  localparam longint CLK_HZ          = 200_000_000;
  localparam longint TICK_MS         = 117;
  localparam longint TICK_CYCLES     = (CLK_HZ / 1000) * TICK_MS;
  localparam longint RESET_PULSE_NS  = 1000;
  localparam longint RESET_PULSE_CYC =
    (RESET_PULSE_NS * CLK_HZ + 999_999_999) / 1_000_000_000;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    WP_IDLE  = 3'b000,
    WP_GOT_A = 3'b001,
    WP_GOT_B = 3'b010,
    WP_GOT_C = 3'b011
  } wp_state_t;

  typedef struct packed {
    logic       wr;    // one-cycle write strobe
    logic       rd;    // one-cycle read strobe
    logic [9:0] addr;  // i/o port address
    logic [7:0] wdata; // write data
  } io_req_t;

  typedef struct packed {
    logic diff_mode;  // differential line when set
    logic ctl_b1;     // bit 1 of line mode
    logic ctl_b2;     // bit 2 of line mode
  } line_mode_t;

endpackage

// ### logic/wd_counter.sv
// watchdog countdown: prescaled tick, then unit count against timeout value
// assumes restart, run and limit come from the register side on i_clk
module wd_counter
  import wdio_pkg::*;
#(
  parameter longint TICK_CYC = TICK_CYCLES  // cycles per 117 ms unit
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic       i_restart,
  input  wire logic [7:0] i_limit,
  output logic            o_expired
);

  initial begin
    if (TICK_CYC < 1) begin
      $error("tick length must be at least one cycle");
    end
  end

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

  logic [31:0] pre_ff;    // cycles within one unit
  logic [7:0]  units_ff;  // whole units elapsed
  logic        exp_ff;    // expiry pulse

  // ==========================================================================
  // prescaler and unit counter; restart or stop clears both
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_ff   <= 32'h0;
      units_ff <= 8'h0;
      exp_ff   <= 1'b0;
    end else if (!i_run || i_restart) begin
      pre_ff   <= 32'h0;
      units_ff <= 8'h0;
      exp_ff   <= 1'b0;
    end else if (pre_ff == TICK_LAST) begin
      pre_ff <= 32'h0;
      // limit reached: fire once and start a fresh period
      if (units_ff + 8'h1 == i_limit) begin
        units_ff <= 8'h0;
        exp_ff   <= 1'b1;
      end else begin
        units_ff <= units_ff + 8'h1;
        exp_ff   <= 1'b0;
      end
    end else begin
      pre_ff <= pre_ff + 32'h1;
      exp_ff <= 1'b0;
    end
  end

  assign o_expired = exp_ff;

endmodule

// ### logic/board_watchdog_io_control.sv
// board i/o register block: watchdog, timeout, write lock, serial line mode
// assumes a byte-wide host i/o bus with one-cycle read and write strobes,
// synchronous to i_clk; read data is registered one cycle after i_rd
module board_watchdog_io_control
  import wdio_pkg::*;
// Functional notes
// - watchdog off after any reset
// - write 40h to 270h enables watchdog
// - write 50h to 270h disables watchdog
// - restart countdown on 60h then 70h, or on 40h
// - timeout equals register 290h times 117 ms
// - timeout value zero keeps watchdog off
// - expiry asserts system reset pulse
// - write-protect port 293h is write only
// - 03h 06h 03h 01h unlocks 290h and 292h
// - 03h 06h 03h 00h relocks 290h and 292h
// - writes to 290h/292h ignored until unlocked
// - 291h bits select line mode and drivers
// - serial number readable at 271h and 272h
// - decode three windows, others reserved
// - 292h download control, writable while unlocked
#(
  parameter logic [15:0] SERIAL_NUMBER = 16'h0001, // arbitrary value
  parameter logic [7:0]  LOGIC_VERSION = 8'h01,    // arbitrary value
  parameter logic [7:0]  BOARD_ID      = 8'h5a,    // arbitrary value
  parameter longint      TICK_CYC      = TICK_CYCLES,
  parameter int          RST_PULSE     = int'(RESET_PULSE_CYC)
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_eeprom_rdata,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  output logic            o_eeprom_wr,
  output logic [7:0]      o_eeprom_wdata,
  output logic            o_sys_reset,
  output logic            o_wd_active,
  output logic            o_wp_unlocked,
  output logic [2:0]      o_line_mode,
  output logic [7:0]      o_dl_ctrl
);

  initial begin
    if (RST_PULSE < 1 || RST_PULSE > 255) begin
      $error("reset pulse length out of range");
    end
  end

  // ==========================================================================
  // reset release synchroniser
  logic rst_meta_ff;  // first stage, read only by the second
  logic rst_n_ff;     // reset copy used by the whole block

  // release through two flops so all flops leave reset on one edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // request decode
  io_req_t req;  // bundled bus request
  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  logic wr_cmd;      // write to watchdog command port
  logic wr_timeout;  // write to timeout register
  logic wr_mode;     // write to line mode register
  logic wr_dl;       // write to download control
  logic wr_wp;       // write to write-protect port
  logic wp_open_ff;  // write protection unlocked

  assign wr_cmd     = req.wr && req.addr == ADDR_WD_CMD;
  assign wr_mode    = req.wr && req.addr == ADDR_LINE_MODE;
  assign wr_wp      = req.wr && req.addr == ADDR_WP_UNLOCK;
  // protected registers only see writes while unlocked
  assign wr_timeout = req.wr && req.addr == ADDR_WD_TIMEOUT
                      && wp_open_ff;
  assign wr_dl      = req.wr && req.addr == ADDR_DL_CTRL
                      && wp_open_ff;
  assign o_eeprom_wr    = req.wr && req.addr == ADDR_EEPROM;
  assign o_eeprom_wdata = req.wdata;

  // ==========================================================================
  // write-protect sequencer
  wp_state_t wp_ff;      // progress through the four-step sequence
  wp_state_t nxt_wp;     // next sequencer state
  logic      nxt_open;   // next lock state

  // walk 03h 06h 03h then 01h or 00h; any stray write starts over
  always_comb begin
    nxt_wp   = wp_ff;
    nxt_open = wp_open_ff;
    if (wr_wp) begin
      unique case (wp_ff)
        WP_IDLE: begin
          nxt_wp = (req.wdata == WP_STEP_A) ? WP_GOT_A : WP_IDLE;
        end
        WP_GOT_A: begin
          nxt_wp = (req.wdata == WP_STEP_B) ? WP_GOT_B
                 : (req.wdata == WP_STEP_A) ? WP_GOT_A : WP_IDLE;
        end
        WP_GOT_B: begin
          nxt_wp = (req.wdata == WP_STEP_A) ? WP_GOT_C : WP_IDLE;
        end
        WP_GOT_C: begin
          // final step decides unlock or relock
          if (req.wdata == WP_UNLOCK_CODE) begin
            nxt_open = 1'b1;
            nxt_wp   = WP_IDLE;
          end else if (req.wdata == WP_LOCK_CODE) begin
            nxt_open = 1'b0;
            nxt_wp   = WP_IDLE;
          end else if (req.wdata == WP_STEP_A) begin
            nxt_wp = WP_GOT_A;  // may be the start of a new sequence
          end else begin
            nxt_wp = WP_IDLE;
          end
        end
        default: begin
          nxt_wp = WP_IDLE;  // illegal codes recover
        end
      endcase
    end
  end

  // lock state: locked after every reset
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wp_ff      <= WP_IDLE;
      wp_open_ff <= 1'b0;
    end else begin
      wp_ff      <= nxt_wp;
      wp_open_ff <= nxt_open;
    end
  end

  // ==========================================================================
  // configuration registers
  logic [7:0] timeout_ff;  // timeout in 117 ms units
  line_mode_t mode_ff;     // serial line mode bits
  logic [7:0] dl_ctrl_ff;  // download control byte

  // timeout register, protected
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      timeout_ff <= TIMEOUT_RESET;
    end else if (wr_timeout) begin
      timeout_ff <= req.wdata;
    end
  end

  // line mode: only bits 2..0 are held, upper bits reserved
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_ff <= line_mode_t'(LINE_MODE_RESET[2:0]);
    end else if (wr_mode) begin
      mode_ff.diff_mode <= req.wdata[LM_DIFF_BIT];
      mode_ff.ctl_b1    <= req.wdata[LM_B1_BIT];
      mode_ff.ctl_b2    <= req.wdata[LM_B2_BIT];
    end
  end

  // download control: stored only, meaning belongs to firmware
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dl_ctrl_ff <= DL_CTRL_RESET;
    end else if (wr_dl) begin
      dl_ctrl_ff <= req.wdata;
    end
  end

  // ==========================================================================
  // watchdog command handling
  logic wd_on_ff;     // software enable
  logic trig_arm_ff;  // first trigger byte seen
  logic restart;      // restart countdown this cycle
  logic wd_run;       // counter running
  logic expired;      // expiry pulse from counter

  // enable flag: off after reset, set by 40h, cleared by 50h
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wd_on_ff <= 1'b0;
    end else if (wr_cmd && req.wdata == CMD_WD_ON) begin
      wd_on_ff <= 1'b1;
    end else if (wr_cmd && req.wdata == CMD_WD_OFF) begin
      wd_on_ff <= 1'b0;
    end
  end

  // trigger pair: 60h arms, 70h right after completes; any other
  // command byte in between drops the arm
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      trig_arm_ff <= 1'b0;
    end else if (wr_cmd) begin
      trig_arm_ff <= (req.wdata == CMD_TRIG_FIRST);
    end
  end

  assign restart = wr_cmd && trig_arm_ff
                   && req.wdata == CMD_TRIG_SECOND;
  // zero timeout keeps it off whatever the enable says
  assign wd_run  = wd_on_ff && timeout_ff != 8'h00;
  // enabling also starts a fresh period
  logic start_pulse;
  assign start_pulse = wr_cmd && req.wdata == CMD_WD_ON;

  // software relies on the trigger pair to keep this from firing
  wd_counter #(
    .TICK_CYC (TICK_CYC)
  ) u_counter (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n_ff),
    .i_run     (wd_run),
    .i_restart (restart || start_pulse),
    .i_limit   (timeout_ff),
    .o_expired (expired)
  );

  // ==========================================================================
  // system reset pulse
  logic [7:0] rst_cnt_ff;  // remaining pulse cycles

  // stretch the expiry into a fixed reset pulse
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rst_cnt_ff <= 8'h00;
    end else if (expired) begin
      rst_cnt_ff <= 8'(RST_PULSE);
    end else if (rst_cnt_ff != 8'h00) begin
      rst_cnt_ff <= rst_cnt_ff - 8'h01;
    end
  end

  assign o_sys_reset = rst_cnt_ff != 8'h00;

  // ==========================================================================
  // read path
  logic [7:0] nxt_rdata;  // combinational read mux
  logic [7:0] rdata_ff;   // registered read data
  logic       rvalid_ff;  // read answer strobe

  // write-only ports and reserved addresses read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (req.addr)
      ADDR_SERIAL_LO:  nxt_rdata = SERIAL_NUMBER[7:0];
      ADDR_SERIAL_HI:  nxt_rdata = SERIAL_NUMBER[15:8];
      ADDR_EEPROM:     nxt_rdata = i_eeprom_rdata;
      ADDR_VERSION:    nxt_rdata = LOGIC_VERSION;
      ADDR_IDENTITY:   nxt_rdata = BOARD_ID;
      ADDR_WD_TIMEOUT: nxt_rdata = timeout_ff;
      ADDR_LINE_MODE:  nxt_rdata = {5'h00, mode_ff.ctl_b2,
                                    mode_ff.ctl_b1, mode_ff.diff_mode};
      ADDR_DL_CTRL:    nxt_rdata = dl_ctrl_ff;
      ADDR_WP_UNLOCK:  nxt_rdata = 8'h00;
      default:         nxt_rdata = 8'h00;
    endcase
  end

  // any read strobe gets an answer one cycle later
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= req.rd;
      rdata_ff  <= req.rd ? nxt_rdata : 8'h00;
    end
  end

  // ==========================================================================
  // outputs
  assign o_rdata       = rdata_ff;
  assign o_rvalid      = rvalid_ff;
  assign o_wd_active   = wd_run;
  assign o_wp_unlocked = wp_open_ff;
  assign o_line_mode   = {mode_ff.ctl_b2, mode_ff.ctl_b1, mode_ff.diff_mode};
  assign o_dl_ctrl     = dl_ctrl_ff;

endmodule

// ### sim/board_watchdog_io_control_monitor.sv
// checker for the board watchdog i/o block, bound onto its top ports
// assumes one clock domain and the block's active-low async reset
module board_watchdog_io_control_monitor
  import wdio_pkg::*;
#(
  parameter logic [15:0] SERIAL_NUMBER = 16'h0001,
  parameter int          RST_PULSE     = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] o_rdata,
  input  wire logic       o_rvalid,
  input  wire logic       o_sys_reset,
  input  wire logic       o_wd_active,
  input  wire logic       o_wp_unlocked,
  input  wire logic [2:0] o_line_mode,
  input  wire logic [7:0] o_dl_ctrl
);
  // ==========================================================================
  // helper logic
  int hi_cnt_ff;  // cycles the reset pulse has been high so far

  // counter instead of a long repetition, pulse length is a parameter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) hi_cnt_ff <= 0;
    else if (o_sys_reset) hi_cnt_ff <= hi_cnt_ff + 1;
    else hi_cnt_ff <= 0;
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_rvalid_follows_rd: assert property (i_rd |=> o_rvalid)
    else $error("read strobe without read answer");
  a_rvalid_one_cycle: assert property (!i_rd |=> !o_rvalid)
    else $error("read answer without read strobe");
  a_rdata_idle_zero: assert property (!o_rvalid |-> o_rdata == 8'h00)
    else $error("read data not zero while idle");
  a_serial_lo_read: assert property (i_rd && i_addr == ADDR_SERIAL_LO
    |=> o_rdata == SERIAL_NUMBER[7:0])
    else $error("serial low byte wrong");
  a_lock_port_zero: assert property (i_rd && i_addr == ADDR_WP_UNLOCK
    |=> o_rdata == 8'h00)
    else $error("write-protect port not read as zero");
  a_off_cmd_stops: assert property (i_wr && i_addr == ADDR_WD_CMD
    && i_wdata == CMD_WD_OFF |=> !o_wd_active)
    else $error("watchdog still active after off command");
  a_locked_dl_hold: assert property (!o_wp_unlocked && i_wr
    && i_addr == ADDR_DL_CTRL |=> $stable(o_dl_ctrl))
    else $error("download control written while locked");
  a_line_mode_wr: assert property (i_wr && i_addr == ADDR_LINE_MODE
    |=> o_line_mode == $past(i_wdata[2:0]))
    else $error("line mode not taken from write");
  a_unlock_cause: assert property ($rose(o_wp_unlocked) |->
    $past(i_wr && i_addr == ADDR_WP_UNLOCK && i_wdata == WP_UNLOCK_CODE))
    else $error("unlock without final unlock byte");
  a_pulse_length: assert property ($fell(o_sys_reset) |->
    hi_cnt_ff == RST_PULSE)
    else $error("system reset pulse length wrong");
  a_expiry_active: assert property ($rose(o_sys_reset) |->
    $past(o_wd_active))
    else $error("system reset while watchdog inactive");
endmodule

bind board_watchdog_io_control board_watchdog_io_control_monitor #(
  .SERIAL_NUMBER(SERIAL_NUMBER),
  .RST_PULSE    (RST_PULSE)
) monitor_i (
  .i_clk        (i_clk),
  .i_arst_n     (i_arst_n),
  .i_wr         (i_wr),
  .i_rd         (i_rd),
  .i_addr       (i_addr),
  .i_wdata      (i_wdata),
  .o_rdata      (o_rdata),
  .o_rvalid     (o_rvalid),
  .o_sys_reset  (o_sys_reset),
  .o_wd_active  (o_wd_active),
  .o_wp_unlocked(o_wp_unlocked),
  .o_line_mode  (o_line_mode),
  .o_dl_ctrl    (o_dl_ctrl)
);

// ### sim/board_watchdog_io_control_tb.sv
// self-checking bench for the board watchdog i/o block
// assumes host byte writes and reads with one-cycle strobes on i_clk
module board_watchdog_io_control_tb
  import wdio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // signals and design
  localparam logic [15:0] SN  = 16'hc3a5;  // arbitrary value
  localparam logic [7:0]  VER = 8'h2b;     // arbitrary value
  localparam logic [7:0]  BID = 8'h6e;     // arbitrary value
  localparam int          RP  = 4;         // short reset pulse
  logic       i_clk, i_arst_n, i_wr, i_rd;
  logic [9:0] i_addr;
  logic [7:0] i_wdata, i_eeprom_rdata, o_rdata, o_eeprom_wdata, o_dl_ctrl;
  logic       o_rvalid, o_eeprom_wr, o_sys_reset, o_wd_active, o_wp_unlocked;
  logic [2:0] o_line_mode;
  int         failures, total_checks, cyc, pulses, p0, c0;
  int         seed = 32'h0535;  // fixed seed, repeatable run
  logic [7:0] v;

  // tick of 4 cycles keeps the 117 ms unit short
  board_watchdog_io_control #(.SERIAL_NUMBER(SN), .LOGIC_VERSION(VER),
    .BOARD_ID(BID), .TICK_CYC(4), .RST_PULSE(RP)) board_watchdog_io_control_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_eeprom_rdata(i_eeprom_rdata),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_eeprom_wr(o_eeprom_wr),
    .o_eeprom_wdata(o_eeprom_wdata), .o_sys_reset(o_sys_reset),
    .o_wd_active(o_wd_active), .o_wp_unlocked(o_wp_unlocked),
    .o_line_mode(o_line_mode), .o_dl_ctrl(o_dl_ctrl));

  // ==========================================================================
  // clock, cycle count, hang guard
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // pulses counts cycles with system reset high
  always @(posedge i_clk) begin
    cyc++;
    if (o_sys_reset) pulses++;
    if (cyc == 3000) begin
      failures++;
      $display("mismatch at %0t: run did not end", $time);
      finish_test();
    end
  end

  // ==========================================================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one byte write, strobe dropped a full cycle later
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask
  // answer stands from the taking edge, checked half a cycle later
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_rd = 1'b1;
    i_addr = a;
    @(negedge i_clk);
    i_rd = 1'b0;
    chk({7'h0, o_rvalid}, 8'h01, "read valid");
    chk(o_rdata, e, "read data");
  endtask
  // four bytes to the write-protect port, first byte in the top lane
  task automatic wp(input logic [31:0] s);
    for (int k = 3; k >= 0; k--) wr(ADDR_WP_UNLOCK, s[8*k +: 8]);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {i_arst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    i_eeprom_rdata = 8'($random(seed));
    repeat (10) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    chk({7'h0, o_wd_active}, 8'h00, "wd off");
    chk({7'h0, o_wp_unlocked}, 8'h00, "locked");
    chk({5'h0, o_line_mode}, LINE_MODE_RESET, "mode");
    chk(o_dl_ctrl, DL_CTRL_RESET, "dl");
    done("reset");
    wr(10'h294, 8'hff);
    rd(ADDR_SERIAL_LO, SN[7:0]);
    rd(ADDR_SERIAL_HI, SN[15:8]);
    rd(ADDR_VERSION, VER);
    rd(ADDR_IDENTITY, BID);
    rd(ADDR_EEPROM, i_eeprom_rdata);
    rd(ADDR_WP_UNLOCK, 8'h00);
    rd(ADDR_WD_CMD, 8'h00);
    rd(10'h294, 8'h00);
    rd(10'h280, 8'h00);
    rd(10'h300, 8'h00);
    @(negedge i_clk);
    i_wr = 1'b1;
    i_addr = ADDR_EEPROM;
    i_wdata = 8'h9c;
    #1 chk({7'h0, o_eeprom_wr}, 8'h01, "eeprom strobe");
    chk(o_eeprom_wdata, 8'h9c, "eeprom data");
    @(negedge i_clk);
    i_wr = 1'b0;
    done("reads");
    // locked: both protected registers refuse writes, timeout stays 0
    wr(ADDR_DL_CTRL, 8'h5d);
    chk(o_dl_ctrl, 8'h00, "dl locked");
    wr(ADDR_WD_TIMEOUT, 8'h02);
    wr(ADDR_WD_CMD, CMD_WD_ON);
    chk({7'h0, o_wd_active}, 8'h00, "zero timeout");
    wr(ADDR_WD_CMD, CMD_WD_OFF);
    wp(32'h03060501);
    chk({7'h0, o_wp_unlocked}, 8'h00, "broken seq");
    wp(32'h03060301);
    chk({7'h0, o_wp_unlocked}, 8'h01, "unlock");
    done("lock");
    // random line mode and download control values
    repeat (8) begin
      v = 8'($random(seed));
      wr(ADDR_LINE_MODE, v);
      chk({5'h0, o_line_mode}, v & LINE_MODE_MASK, "mode");
      rd(ADDR_LINE_MODE, v & LINE_MODE_MASK);
      wr(ADDR_DL_CTRL, ~v);
      chk(o_dl_ctrl, ~v, "dl");
    end
    done("modes");
    // two units of 4 cycles, triggered every 4 cycles
    wr(ADDR_WD_TIMEOUT, 8'h02);
    wr(ADDR_WD_CMD, CMD_WD_ON);
    chk({7'h0, o_wd_active}, 8'h01, "wd on");
    p0 = pulses;
    repeat (6) begin
      wr(ADDR_WD_CMD, CMD_TRIG_FIRST);
      wr(ADDR_WD_CMD, CMD_TRIG_SECOND);
    end
    chk(8'(pulses - p0), 8'h00, "trigger kept");
    repeat (4) wr(ADDR_WD_CMD, CMD_TRIG_SECOND);
    // expiry lands on the edge taking the last write; pulse counted two edges later
    repeat (3) @(negedge i_clk);
    chk({7'h0, pulses > p0}, 8'h01, "lone second byte");
    wr(ADDR_WD_CMD, CMD_WD_OFF);
    repeat (RP + 2) @(negedge i_clk);
    wr(ADDR_WD_CMD, CMD_WD_ON);
    c0 = cyc;
    for (int k = 0; k < 40 && !o_sys_reset; k++) @(negedge i_clk);
    chk({7'h0, cyc - c0 >= 8 && cyc - c0 <= 11}, 8'h01, "period");
    done("expiry");
    wr(ADDR_WD_CMD, CMD_WD_OFF);
    chk({7'h0, o_wd_active}, 8'h00, "wd off");
    repeat (RP + 2) @(negedge i_clk);
    p0 = pulses;
    repeat (30) @(negedge i_clk);
    chk(8'(pulses - p0), 8'h00, "no expiry");
    wp(32'h03060300);
    chk({7'h0, o_wp_unlocked}, 8'h00, "relock");
    wr(ADDR_WD_TIMEOUT, 8'h00);
    wr(ADDR_WD_CMD, CMD_WD_ON);
    chk({7'h0, o_wd_active}, 8'h01, "timeout kept");
    wr(ADDR_WD_CMD, CMD_WD_OFF);
    done("relock");
    finish_test();
  end
endmodule
